/* File: bench/ccc_host_model.sv */
// Purpose: Host and converter model that drives the coulomb counter core.
// Assumes: All stimulus changes on the falling edge of mclk.
// Notes:   The testbench calls these tasks by hierarchical name.
`timescale 1ns/1ps

module ccc_host_model (
    input  wire logic       mclk,
    output logic            vfcPulse,
    output logic            vfcNegative,
    output logic            offsetPulse,
    output logic            sleepCmd,
    output logic [4:0]      counterClearSet,
    output logic            dqIn
);
    initial begin
        vfcPulse        = 1'b0;
        vfcNegative     = 1'b0;
        offsetPulse     = 1'b0;
        sleepCmd        = 1'b0;
        counterClearSet = 5'h00;
        dqIn            = 1'b1;
    end

    // A long hold checks that one converter pulse never counts twice.
    task automatic pulse(input logic neg, input int hold, input logic offs);
        @(negedge mclk);
        vfcNegative = neg;
        if (offs) offsetPulse = 1'b1;
        else vfcPulse = 1'b1;
        repeat (hold) @(negedge mclk);
        vfcPulse    = 1'b0;
        offsetPulse = 1'b0;
        @(negedge mclk);
    endtask : pulse

    task automatic sleep();
        @(negedge mclk);
        sleepCmd = 1'b1;
        @(negedge mclk);
        sleepCmd = 1'b0;
    endtask : sleep

    task automatic clear(input logic [4:0] mask);
        @(negedge mclk);
        counterClearSet = mask;
        @(negedge mclk);
        counterClearSet = 5'h00;
    endtask : clear

    task automatic lineEdge();
        @(negedge mclk);
        dqIn = ~dqIn;
    endtask : lineEdge
endmodule : ccc_host_model

/* File: bench/coulomb_counter_core_test.sv */
// Purpose: Self-checking testbench of the coulomb counter core.
// Assumes: Short tick of 20 cycles so timers move within the run.
// Notes:   Rollover into the slow rate is too long to reach here.
`timescale 1ns/1ps

module coulomb_counter_core_test;
    import ccc_pkg::*;
    localparam int TICK = 20;
    logic mclk, rst_n, vfcPulse, vfcNegative, offsetPulse, sleepCmd, dqIn;
    logic regulatorDisable, statusLevel, asleep, regulatorOn, statusOut, statusOe;
    logic [11:0]    senseMagUv;
    logic [8:0]     dieKelvin;
    logic [2:0]     wakeThresholdSelect;
    logic [4:0]     counterClearSet, counterClearControl;
    logic [3:0]     readSel;
    logic [7:0]     readByte, temperatureHigh, temperatureLow;
    ccc_counts_type counts;
    ccc_flags_type  flags;
    logic [11:0]    wakeUv [8] = '{12'h000, 12'h0DBC, 12'h06DE, 12'h0494,
                                   12'h036F, 12'h02BF, 12'h024A, 12'h01F6};
    logic [15:0]    snap;
    int err_count = 0;
    int comparisons = 0;

    ccc_core #(.TICK_CYCLES(TICK)) ccc_core_i (.mclk(mclk), .rst_n(rst_n),
        .vfcPulse(vfcPulse), .vfcNegative(vfcNegative), .offsetPulse(offsetPulse),
        .senseMagUv(senseMagUv), .dieKelvin(dieKelvin), .sleepCmd(sleepCmd),
        .wakeThresholdSelect(wakeThresholdSelect), .regulatorDisable(regulatorDisable),
        .statusLevel(statusLevel), .counterClearSet(counterClearSet), .dqIn(dqIn),
        .readSel(readSel), .counts(counts), .flags(flags),
        .counterClearControl(counterClearControl), .readByte(readByte),
        .temperatureHigh(temperatureHigh), .temperatureLow(temperatureLow),
        .asleep(asleep), .regulatorOn(regulatorOn), .statusOut(statusOut),
        .statusOe(statusOe));
    ccc_host_model ccc_host_model_i (.mclk(mclk), .vfcPulse(vfcPulse),
        .vfcNegative(vfcNegative), .offsetPulse(offsetPulse), .sleepCmd(sleepCmd),
        .counterClearSet(counterClearSet), .dqIn(dqIn));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic rd(input logic [3:0] sel, input logic [7:0] exp);
        @(negedge mclk);
        readSel = sel;
        cyc(1);
        check("readByte", readByte, exp);
    endtask : rd

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        cyc(30000);
        err_count++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0; senseMagUv = 12'h000; dieKelvin = 9'h12A; readSel = 4'h0;
        wakeThresholdSelect = 3'h0; regulatorDisable = 1'b0; statusLevel = 1'b0;
        cyc(5);
        check("counts", counts, '0);
        check("regulatorOn", regulatorOn, 1'b0);
        rst_n = 1'b1;
        cyc(2);
        check("regulatorOn", regulatorOn, 1'b1);
        check("statusOe", {statusOut, statusOe}, 2'b01);
        ccc_host_model_i.pulse(1'b1, 3, 1'b0);
        check("dischargeCount", counts[0], 16'h0001);
        check("chargeIdle", counts[1], 16'h0000);
        ccc_host_model_i.pulse(1'b0, 1, 1'b0);
        check("chargeCount", counts[1], 16'h0001);
        check("dischargeHeld", counts[0], 16'h0001);
        ccc_host_model_i.pulse(1'b1, 1, 1'b1);
        ccc_host_model_i.pulse(1'b1, 1, 1'b0);
        check("offsetSpent", counts[0], 16'h0001);
        ccc_host_model_i.pulse(1'b1, 1, 1'b0);
        check("dischargeAgain", counts[0], 16'h0002);
        rd(4'h0, 8'h02);
        rd(4'h1, 8'h00);
        rd(4'hB, 8'h01);
        check("temperatureLow", temperatureLow, 8'h2A);
        check("temperatureHigh", temperatureHigh, 8'h01);
        // Discharge activity: the discharge timer steps once per tick.
        senseMagUv = 12'h100;
        cyc(TICK * 2);
        snap = counts[3];
        cyc(TICK);
        check("dischargeTimer", counts[3], snap + 16'h0001);
        check("chargeTimerIdle", counts[4], 16'h0000);
        ccc_host_model_i.clear(5'h08);
        check("timerCleared", counts[3], 16'h0000);
        check("slowFlags", flags, 2'b00);
        // Hottest band: 512 ticks make one self-discharge count.
        dieKelvin = 9'h148;
        ccc_host_model_i.clear(5'h04);
        check("clearControl", counterClearControl, 5'h04);
        check("selfCleared", counts[2], 16'h0000);
        cyc(1);
        check("clearDropped", counterClearControl, 5'h00);
        cyc(TICK * 520);
        check("selfCount", counts[2], 16'h0001);
        // Activity at the threshold keeps the core pending, awake.
        wakeThresholdSelect = 3'h7;
        senseMagUv = wakeUv[7];
        ccc_host_model_i.sleep();
        cyc(3);
        check("notQuiet", asleep, 1'b0);
        ccc_host_model_i.lineEdge();
        wakeThresholdSelect = 3'h1;
        senseMagUv = wakeUv[1] - 12'h001;
        ccc_host_model_i.sleep();
        cyc(1);
        check("asleep", asleep, 1'b1);
        ccc_host_model_i.pulse(1'b0, 1, 1'b0);
        check("asleepFrozen", counts[1], 16'h0001);
        ccc_host_model_i.lineEdge();
        cyc(1);
        check("woken", asleep, 1'b0);
        regulatorDisable = 1'b1;
        statusLevel = 1'b1;
        cyc(2);
        check("regulatorOff", regulatorOn, 1'b0);
        check("statusRel", {statusOut, statusOe}, 2'b00);
        // Second reset in mid-run.
        rst_n = 1'b0;
        cyc(2);
        check("countsReset", counts, '0);
        rst_n = 1'b1;
        cyc(2);
        check("regAfterReset", regulatorOn, 1'b0);
        end_sim();
    end
endmodule : coulomb_counter_core_test

/* File: src/ccc_cfg.svh */
// Purpose: Constants of the coulomb counter core.
// Assumes: 200 MHz mclk.
// Notes:   Counter indices double as clear-request bit positions.
`ifndef CCC_CFG_SVH
`define CCC_CFG_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CCC_CLK_MHZ      200
`define CCC_TICK_US      878900
`define CCC_SLOW_LAST    8'hFF
`define CCC_SELF_UNIT    8'h10
`define CCC_SELF_LIMIT   17'h1_0000

// ----------------------------------------------------------------------
// Counter indices and clear bits
// ----------------------------------------------------------------------
`define CCC_IDX_DIS      0
`define CCC_IDX_CHG      1
`define CCC_IDX_SELF     2
`define CCC_IDX_DTIME    3
`define CCC_IDX_CTIME    4
`define CCC_NUM_CNT      5

// ----------------------------------------------------------------------
// Wake thresholds in microvolts, codes 1 to 7
// ----------------------------------------------------------------------
`define CCC_WAKE_1       12'h0DBC
`define CCC_WAKE_2       12'h06DE
`define CCC_WAKE_3       12'h0494
`define CCC_WAKE_4       12'h036F
`define CCC_WAKE_5       12'h02BF
`define CCC_WAKE_6       12'h024A
`define CCC_WAKE_7       12'h01F6

// ----------------------------------------------------------------------
// Die temperature bands in kelvin
// ----------------------------------------------------------------------
`define CCC_K_55C        9'h148
`define CCC_K_45C        9'h13E
`define CCC_K_35C        9'h134
`define CCC_K_25C        9'h12A
`define CCC_K_15C        9'h120
`define CCC_K_5C         9'h116

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CCC_CNT_RST      16'h0000
`define CCC_CREDIT_RST   8'h00

`endif

/* File: src/ccc_core.sv */
// Purpose: Charge, discharge, time and self-discharge counting core.
// Assumes: All inputs are synchronous to mclk; converter pulses are levels.
// Notes:   Counters are read bytewise through readSel.
`timescale 1ns/1ps
`include "ccc_cfg.svh"

module ccc_core
    import ccc_pkg::*;
#(
    parameter int TICK_CYCLES = `CCC_TICK_US * `CCC_CLK_MHZ
) (
    input  wire logic           mclk,
    input  wire logic           rst_n,
    input  wire logic           vfcPulse,
    input  wire logic           vfcNegative,
    input  wire logic           offsetPulse,
    input  wire logic [11:0]    senseMagUv,
    input  wire logic [8:0]     dieKelvin,
    input  wire logic           sleepCmd,
    input  wire logic [2:0]     wakeThresholdSelect,
    input  wire logic           regulatorDisable,
    input  wire logic           statusLevel,
    input  wire logic [4:0]     counterClearSet,
    input  wire logic           dqIn,
    input  wire logic [3:0]     readSel,
    output ccc_counts_type      counts,
    output ccc_flags_type       flags,
    output logic [4:0]          counterClearControl,
    output logic [7:0]          readByte,
    output logic [7:0]          temperatureHigh,
    output logic [7:0]          temperatureLow,
    output logic                asleep,
    output logic                regulatorOn,
    output logic                statusOut,
    output logic                statusOe
);

    // ------------------------------------------------------------------
    // Timebase and pulse edges
    // ------------------------------------------------------------------
    logic [27:0]    tickCnt, next_tickCnt;
    logic           tickPulse, next_tickPulse;
    logic           vfcPrev, offPrev, dqPrev;
    logic           vfcEdge, offEdge, run, disActive, chgActive;
    ccc_sleep_type  sleepState, next_sleepState;

    always_comb begin
        next_tickPulse = (tickCnt == 28'(TICK_CYCLES - 1));
        next_tickCnt = next_tickPulse ? 28'h000_0000 : tickCnt + 28'h000_0001;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt   <= 28'h000_0000;
            tickPulse <= 1'b0;
            vfcPrev   <= 1'b0;
            offPrev   <= 1'b0;
            dqPrev    <= 1'b0;
        end else begin
            tickCnt   <= next_tickCnt;
            tickPulse <= next_tickPulse;
            vfcPrev   <= vfcPulse;
            offPrev   <= offsetPulse;
            dqPrev    <= dqIn;
        end
    end

    // One increment per rising edge, however long the pulse stands.
    assign vfcEdge   = vfcPulse & ~vfcPrev;
    assign offEdge   = offsetPulse & ~offPrev;
    assign run       = (sleepState != CCC_ASLEEP);
    assign disActive = run & vfcNegative & (senseMagUv != 12'h000);
    assign chgActive = run & ~vfcNegative & (senseMagUv != 12'h000);

    // ------------------------------------------------------------------
    // Offset credits
    // ------------------------------------------------------------------
    // Offset pulses bank a credit per polarity; a later signal pulse of that
    // polarity spends the credit instead of counting.
    logic [7:0] creditDis, creditChg, next_creditDis, next_creditChg;
    logic       countDis, countChg;

    always_comb begin
        countDis = vfcEdge & vfcNegative & run & (creditDis == 8'h00);
        countChg = vfcEdge & ~vfcNegative & run & (creditChg == 8'h00);
        next_creditDis = creditDis;
        next_creditChg = creditChg;
        if (vfcEdge && vfcNegative && run && creditDis != 8'h00) begin
            next_creditDis = creditDis - 8'h01;
        end else if (offEdge && vfcNegative && creditDis != 8'hFF) begin
            next_creditDis = creditDis + 8'h01;
        end
        if (vfcEdge && !vfcNegative && run && creditChg != 8'h00) begin
            next_creditChg = creditChg - 8'h01;
        end else if (offEdge && !vfcNegative && creditChg != 8'hFF) begin
            next_creditChg = creditChg + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            creditDis <= `CCC_CREDIT_RST;
            creditChg <= `CCC_CREDIT_RST;
        end else begin
            creditDis <= next_creditDis;
            creditChg <= next_creditChg;
        end
    end

    // ------------------------------------------------------------------
    // Self-discharge rate
    // ------------------------------------------------------------------
    // Weight 16 per tick at 25 C; 4096 ticks make one hour, so the limit
    // is 4096 times 16. Bands are whole kelvin, hence only roughly 10 C.
    function automatic logic [7:0] selfWeight(input logic [8:0] k);
        if (k >= `CCC_K_55C)      selfWeight = 8'h80;
        else if (k >= `CCC_K_45C) selfWeight = 8'h40;
        else if (k >= `CCC_K_35C) selfWeight = 8'h20;
        else if (k >= `CCC_K_25C) selfWeight = `CCC_SELF_UNIT;
        else if (k >= `CCC_K_15C) selfWeight = 8'h08;
        else if (k >= `CCC_K_5C)  selfWeight = 8'h04;
        else                      selfWeight = 8'h02;
    endfunction : selfWeight

    logic [16:0] selfAcc, next_selfAcc, selfSum;
    logic        selfStep;

    always_comb begin
        selfSum      = selfAcc + {9'h000, selfWeight(dieKelvin)};
        selfStep     = tickPulse && (selfSum >= `CCC_SELF_LIMIT);
        next_selfAcc = selfAcc;
        if (counterClearSet[`CCC_IDX_SELF]) begin
            next_selfAcc = 17'h0_0000;
        end else if (tickPulse) begin
            next_selfAcc = selfStep ? selfSum - `CCC_SELF_LIMIT : selfSum;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            selfAcc <= 17'h0_0000;
        end else begin
            selfAcc <= next_selfAcc;
        end
    end

    // ------------------------------------------------------------------
    // Counters, slow flags and clear bits
    // ------------------------------------------------------------------
    logic [4:0]     inc;
    logic [7:0]     slowSubDis, slowSubChg, next_slowSubDis, next_slowSubChg;
    ccc_counts_type next_counts;
    ccc_flags_type  next_flags;

    always_comb begin
        inc[`CCC_IDX_DIS]   = countDis;
        inc[`CCC_IDX_CHG]   = countChg;
        inc[`CCC_IDX_SELF]  = selfStep;
        inc[`CCC_IDX_DTIME] = tickPulse & disActive &
                              (~flags.slowDischarge | (slowSubDis == `CCC_SLOW_LAST));
        inc[`CCC_IDX_CTIME] = tickPulse & chgActive &
                              (~flags.slowCharge | (slowSubChg == `CCC_SLOW_LAST));
        next_slowSubDis = slowSubDis;
        next_slowSubChg = slowSubChg;
        if (counterClearSet[`CCC_IDX_DTIME]) begin
            next_slowSubDis = 8'h00;
        end else if (tickPulse && disActive && flags.slowDischarge) begin
            next_slowSubDis = slowSubDis + 8'h01;
        end
        if (counterClearSet[`CCC_IDX_CTIME]) begin
            next_slowSubChg = 8'h00;
        end else if (tickPulse && chgActive && flags.slowCharge) begin
            next_slowSubChg = slowSubChg + 8'h01;
        end
        // A rollover in the same cycle as a clear still sets the flag.
        next_flags.slowDischarge = (inc[`CCC_IDX_DTIME] &&
                                    counts[`CCC_IDX_DTIME] == 16'hFFFF) ||
                                   (flags.slowDischarge &&
                                    !counterClearSet[`CCC_IDX_DTIME]);
        next_flags.slowCharge    = (inc[`CCC_IDX_CTIME] &&
                                    counts[`CCC_IDX_CTIME] == 16'hFFFF) ||
                                   (flags.slowCharge &&
                                    !counterClearSet[`CCC_IDX_CTIME]);
    end

    for (genvar g = 0; g < `CCC_NUM_CNT; g++) begin : gCnt
        // Plain 16-bit wrap; the slow rate is handled by inc.
        assign next_counts[g] = counterClearSet[g] ? `CCC_CNT_RST :
                                inc[g] ? counts[g] + 16'h0001 : counts[g];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            counts              <= '0;
            flags               <= '0;
            slowSubDis          <= 8'h00;
            slowSubChg          <= 8'h00;
            counterClearControl <= 5'h00;
        end else begin
            counts              <= next_counts;
            flags               <= next_flags;
            slowSubDis          <= next_slowSubDis;
            slowSubChg          <= next_slowSubChg;
            // Bit is up while the zeroing lands, then drops unless re-set.
            counterClearControl <= counterClearSet;
        end
    end

    // ------------------------------------------------------------------
    // Sleep control
    // ------------------------------------------------------------------
    logic [11:0] wakeLimit;
    logic        quiet, dqEdge;

    always_comb begin
        case (wakeThresholdSelect)
            3'h1:    wakeLimit = `CCC_WAKE_1;
            3'h2:    wakeLimit = `CCC_WAKE_2;
            3'h3:    wakeLimit = `CCC_WAKE_3;
            3'h4:    wakeLimit = `CCC_WAKE_4;
            3'h5:    wakeLimit = `CCC_WAKE_5;
            3'h6:    wakeLimit = `CCC_WAKE_6;
            3'h7:    wakeLimit = `CCC_WAKE_7;
            default: wakeLimit = 12'h000;
        endcase
        // Code zero sets no threshold, so sleep follows the command after one cycle in CCC_PEND.
        quiet  = (wakeThresholdSelect == 3'h0) || (senseMagUv < wakeLimit);
        dqEdge = (dqIn != dqPrev);
        next_sleepState = sleepState;
        case (sleepState)
            CCC_AWAKE: begin
                if (sleepCmd) begin
                    next_sleepState = CCC_PEND;
                end
            end
            CCC_PEND: begin
                if (dqEdge) begin
                    next_sleepState = CCC_AWAKE;
                end else if (quiet) begin
                    next_sleepState = CCC_ASLEEP;
                end
            end
            CCC_ASLEEP: begin
                if (dqEdge) begin
                    next_sleepState = CCC_AWAKE;
                end
            end
            default: next_sleepState = CCC_AWAKE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sleepState <= CCC_AWAKE;
        end else begin
            sleepState <= next_sleepState;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic [7:0] next_readByte;

    always_comb begin
        case (readSel)
            4'h0:    next_readByte = counts[0][7:0];
            4'h1:    next_readByte = counts[0][15:8];
            4'h2:    next_readByte = counts[1][7:0];
            4'h3:    next_readByte = counts[1][15:8];
            4'h4:    next_readByte = counts[2][7:0];
            4'h5:    next_readByte = counts[2][15:8];
            4'h6:    next_readByte = counts[3][7:0];
            4'h7:    next_readByte = counts[3][15:8];
            4'h8:    next_readByte = counts[4][7:0];
            4'h9:    next_readByte = counts[4][15:8];
            4'hA:    next_readByte = dieKelvin[7:0];
            4'hB:    next_readByte = {7'h00, dieKelvin[8]};
            default: next_readByte = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            readByte        <= 8'h00;
            temperatureHigh <= 8'h00;
            temperatureLow  <= 8'h00;
            asleep          <= 1'b0;
            regulatorOn     <= 1'b0;
            statusOut       <= 1'b0;
            statusOe        <= 1'b0;
        end else begin
            readByte        <= next_readByte;
            temperatureHigh <= {7'h00, dieKelvin[8]};
            temperatureLow  <= dieKelvin[7:0];
            asleep          <= (next_sleepState == CCC_ASLEEP);
            regulatorOn     <= !regulatorDisable;
            statusOut       <= 1'b0;
            statusOe        <= !statusLevel;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    dis_count_step_a: assert property (countDis && !counterClearSet[0]
        |=> counts[0] == $past(counts[0]) + 16'h0001) else $error("discharge count missed");
    chg_count_step_a: assert property (countChg && !counterClearSet[1]
        |=> counts[1] == $past(counts[1]) + 16'h0001) else $error("charge count missed");
    one_polarity_a: assert property (!(inc[0] && inc[1]))
        else $error("both counts stepped");
    slow_flag_set_a: assert property (inc[3] && counts[3] == 16'hFFFF
        |=> flags.slowDischarge && counts[3] == 16'h0000) else $error("rollover no flag");
    slow_flag_clear_a: assert property (counterClearSet[4] && !inc[4]
        |=> !flags.slowCharge) else $error("slow flag kept");
    clear_zero_a: assert property (counterClearSet[2]
        |=> counts[2] == 16'h0000 && counterClearControl[2]) else $error("clear failed");
    clear_drop_a: assert property (counterClearControl[2] && !counterClearSet[2]
        |=> !counterClearControl[2]) else $error("clear bit stuck");
    sleep_freeze_a: assert property (asleep && !counterClearSet[1]
        |=> $stable(counts[1])) else $error("count while asleep");
    dq_wake_a: assert property (sleepState == CCC_ASLEEP && dqEdge
        |=> !asleep && sleepState == CCC_AWAKE) else $error("no wake on line edge");
    regulator_off_a: assert property (regulatorDisable [*2]
        |-> !regulatorOn) else $error("regulator still on");

    sleep_entry_c: cover property (sleepState == CCC_PEND ##1 sleepState == CCC_ASLEEP);
    offset_spend_c: cover property (vfcEdge && creditDis != 8'h00);
    self_step_c: cover property (selfStep);

endmodule : ccc_core

/* File: src/ccc_pkg.sv */
// Purpose: Types of the coulomb counter core.
// Assumes: Constants come from ccc_cfg.svh.
// Notes:   Counter order: discharge, charge, self-discharge, two timers.
package ccc_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [4:0][15:0] ccc_counts_type;

    typedef struct packed {
        logic slowDischarge;
        logic slowCharge;
    } ccc_flags_type;

    typedef enum logic [1:0] {
        CCC_AWAKE  = 2'b00,
        CCC_PEND   = 2'b01,
        CCC_ASLEEP = 2'b10
    } ccc_sleep_type;

endpackage : ccc_pkg
